// ==== testbench/testbench.sv ====
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module testbench;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_awaddr = 4'h0;
  logic [3:0] s_araddr = 4'h0;
  logic [3:0] s_wstrb = 4'hf;
  logic [31:0] s_wdata = 32'h0;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic hw_trigger_in = 1'b0;
  logic cmp_above = 1'b0;
  logic [1:0] tick_cnt = 2'h0;
  logic local_tick, alt_tick;
  logic [1:0] last_rresp;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp;
  logic [31:0] s_rdata, rd;
  logic [4:0] mux_channel;
  logic [9:0] dac_code;
  logic mux_isolate, sar_power_on, sample_en, conv_active, irq;
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #50 aclk = ~aclk;

  // slow conversion clock enables: every second and every fourth cycle
  always @(posedge aclk) tick_cnt <= tick_cnt + 2'h1;
  assign local_tick = tick_cnt[0];
  assign alt_tick = tick_cnt == 2'h3;

  sacs_top dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .hw_trigger_in(hw_trigger_in), .alt_clk_tick(alt_tick), .local_clk_tick(local_tick),
    .cmp_above(cmp_above), .mux_channel(mux_channel), .mux_isolate(mux_isolate),
    .sar_power_on(sar_power_on), .sample_en(sample_en), .dac_code(dac_code),
    .conv_active(conv_active), .irq(irq)
  );

  // ----------------------------------------
  // bus and wait tasks
  // ----------------------------------------
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic aw_hs, w_hs, b_hs;
    logic [1:0] resp;
    int n;
    n = 0;
    b_hs = 1'b0;
    resp = 2'h0;
    @(posedge aclk);
    s_awaddr <= a;
    s_awvalid <= 1'b1;
    s_wdata <= d;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (!b_hs && n < 200) begin
      @(negedge aclk);
      aw_hs = s_awvalid & s_awready;
      w_hs = s_wvalid & s_wready;
      b_hs = s_bvalid & s_bready;
      resp = s_bresp;
      @(posedge aclk);
      if (aw_hs) s_awvalid <= 1'b0;
      if (w_hs) s_wvalid <= 1'b0;
      if (b_hs) s_bready <= 1'b0;
      n++;
    end
    @(negedge aclk);
    `CHK("write answer", 1'b1, b_hs)
    `CHK("write response", sacs_pkg::RESP_OK, resp)
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    logic ar_hs, r_hs;
    int n;
    n = 0;
    r_hs = 1'b0;
    d = 32'h0;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    while (!r_hs && n < 200) begin
      @(negedge aclk);
      ar_hs = s_arvalid & s_arready;
      r_hs = s_rvalid & s_rready;
      d = s_rdata;
      last_rresp = s_rresp;
      @(posedge aclk);
      if (ar_hs) s_arvalid <= 1'b0;
      if (r_hs) s_rready <= 1'b0;
      n++;
    end
    @(negedge aclk);
    `CHK("read answer", 1'b1, r_hs)
    `CHK("read response", sacs_pkg::RESP_OK, last_rresp)
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge aclk);
  endtask

  // waits for irq high, or for the converter to power down
  task automatic wait_evt(input bit on_irq);
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (n < 400 && (on_irq ? irq !== 1'b1 : sar_power_on !== 1'b0));
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles++;
    if (cycles >= 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    `CHK("isolate after reset", 1'b1, mux_isolate)
    `CHK("power after reset", 1'b0, sar_power_on)
    axi_rd(sacs_pkg::OFF_SC1, rd);
    `CHK("control one reset", 32'h0000001f, rd)
    $display("test reset done");

    axi_wr(sacs_pkg::OFF_SC1, 32'h45);
    `CHK("started", 1'b1, sar_power_on)
    `CHK("active mirror", 1'b1, conv_active)
    `CHK("sampling", 1'b1, sample_en)
    `CHK("channel", 5'h05, mux_channel)
    `CHK("isolate", 1'b0, mux_isolate)
    axi_rd(sacs_pkg::OFF_SC2, rd);
    `CHK("active bit", 32'h00000080, rd)
    wait_evt(1'b1);
    `CHK("irq on done", 1'b1, irq)
    wait_cyc(5);
    `CHK("irq level", 1'b1, irq)
    `CHK("low power", 1'b0, sar_power_on)
    axi_rd(sacs_pkg::OFF_SC1, rd);
    `CHK("done flag", 32'h000000c5, rd)
    axi_rd(sacs_pkg::OFF_RES, rd);
    `CHK("result ten bit", 32'h000003ff, rd)
    `CHK("dac code", 10'h3ff, dac_code)
    `CHK("irq cleared", 1'b0, irq)
    wait_cyc(40);
    `CHK("single only", 1'b0, irq)
    `CHK("stays off", 1'b0, sar_power_on)
    $display("test single done");

    axi_wr(sacs_pkg::OFF_SC1, 32'h63);
    wait_evt(1'b1);
    axi_rd(sacs_pkg::OFF_RES, rd);
    wait_evt(1'b1);
    `CHK("second conversion", 1'b1, irq)
    `CHK("still running", 1'b1, sar_power_on)
    axi_wr(sacs_pkg::OFF_SC1, 32'h7f);
    `CHK("off write clears", 1'b0, irq)
    `CHK("off power", 1'b0, sar_power_on)
    `CHK("off isolate", 1'b1, mux_isolate)
    wait_cyc(40);
    `CHK("no extra conversion", 1'b0, irq)
    axi_rd(sacs_pkg::OFF_SC1, rd);
    `CHK("off status", 32'h0000007f, rd)
    $display("test continuous done");

    @(posedge aclk);
    cmp_above <= 1'b1;
    axi_wr(sacs_pkg::OFF_CMP, 32'h301);
    axi_rd(sacs_pkg::OFF_CMP, rd);
    `CHK("compare value", 32'h00000301, rd)
    for (int g = 0; g < 2; g++) begin
      axi_wr(sacs_pkg::OFF_SC2, 32'h20 | (g << 4));
      axi_wr(sacs_pkg::OFF_SC1, 32'h01);
      wait_evt(1'b0);
      axi_rd(sacs_pkg::OFF_SC1, rd);
      `CHK("compare qualified", (g == 0) ? 32'h81 : 32'h01, rd)
      `CHK("irq masked", 1'b0, irq)
    end
    axi_wr(sacs_pkg::OFF_SC2, 32'h0);
    axi_wr(sacs_pkg::OFF_SC1, 32'h01);
    wait_evt(1'b0);
    axi_rd(sacs_pkg::OFF_RES, rd);
    `CHK("result zero", 32'h00000000, rd)
    @(posedge aclk);
    cmp_above <= 1'b0;
    axi_wr(sacs_pkg::OFF_SC2, 32'h08);
    axi_wr(sacs_pkg::OFF_SC1, 32'h42);
    wait_evt(1'b1);
    axi_rd(sacs_pkg::OFF_RES, rd);
    `CHK("result eight bit", 32'h000000ff, rd)
    $display("test compare done");

    axi_wr(sacs_pkg::OFF_SC2, 32'h40);
    axi_wr(sacs_pkg::OFF_SC1, 32'h42);
    wait_cyc(40);
    `CHK("no soft start", 1'b0, sar_power_on)
    `CHK("no soft done", 1'b0, irq)
    @(posedge aclk);
    hw_trigger_in <= 1'b1;
    wait_cyc(3);
    @(posedge aclk);
    hw_trigger_in <= 1'b0;
    wait_evt(1'b1);
    `CHK("hw start", 1'b1, irq)
    axi_rd(sacs_pkg::OFF_RES, rd);
    wait_cyc(40);
    `CHK("one per trigger", 1'b0, irq)
    $display("test hardware trigger done");

    for (int k = 1; k < 4; k++) begin
      axi_wr(sacs_pkg::OFF_SC2, 32'(k));
      axi_wr(sacs_pkg::OFF_SC1, 32'h41);
      wait_cyc(20);
      `CHK("slow clock busy", 1'b0, irq)
      wait_evt(1'b1);
      `CHK("slow clock done", 1'b1, irq)
      axi_rd(sacs_pkg::OFF_RES, rd);
    end
    $display("test clock select done");

    axi_wr(sacs_pkg::OFF_SC2, 32'h0);
    for (int c = 0; c <= 27; c++) begin
      axi_wr(sacs_pkg::OFF_SC1, 32'(c));
      `CHK("channel code", 5'(c), mux_channel)
      `CHK("channel open", 1'b0, mux_isolate)
    end
    axi_wr(sacs_pkg::OFF_SC1, 32'h1f);
    `CHK("final off", 1'b1, mux_isolate)
    $display("test channels done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ==== verilog/sacs_pkg.sv ====
// shared constants and types for the converter control block
package sacs_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFF_SC1 = 4'h0;
  localparam logic [3:0] OFF_SC2 = 4'h4;
  localparam logic [3:0] OFF_RES = 4'h8;
  localparam logic [3:0] OFF_CMP = 4'hc;
  localparam int unsigned RES_W = 10;
  localparam int unsigned CH_W = 5;
  localparam logic [4:0] CH_OFF = 5'h1f;
  localparam logic [4:0] CH_LAST = 5'h1b;
  localparam int unsigned SC1_DONE = 7;
  localparam int unsigned SC1_IEN = 6;
  localparam int unsigned SC1_CONT = 5;
  localparam int unsigned SC2_ACT = 7;
  localparam int unsigned SC2_TRG = 6;
  localparam int unsigned SC2_CMPE = 5;
  localparam int unsigned SC2_GTE = 4;
  localparam int unsigned SC2_M8 = 3;
  localparam int unsigned SC2_CLK = 0;
  localparam logic [7:0] SC1_RST = 8'h1f;
  localparam logic [7:0] SC2_RST = 8'h00;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [1:0] CLK_BUS = 2'h0;
  localparam logic [1:0] CLK_HALF = 2'h1;
  localparam logic [1:0] CLK_LOCAL = 2'h2;
  localparam logic [1:0] CLK_ALT = 2'h3;
  localparam logic [3:0] SETTLE_CYC = 4'h3;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_BITS = 2'b11,
    ST_DONE = 2'b10
  } sacs_state_t;
  typedef struct packed {
    logic done;
    logic ien;
    logic cont;
    logic [4:0] ch;
  } sacs_sc1_t;
  typedef struct packed {
    logic trig_hw;
    logic cmp_en;
    logic cmp_gte;
    logic mode8;
    logic [1:0] clk_sel;
  } sacs_cfg_t;
endpackage

// ==== verilog/sacs_sar_core.sv ====
// successive-approximation search engine
`timescale 1ns/1ps
`default_nettype none
module sacs_sar_core (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic step_en,
  input wire logic start,
  input wire logic abort,
  // comparator
  input wire logic cmp_above,
  // search state
  output logic [9:0] trial,
  output logic busy,
  output logic finish
);
  logic [9:0] trial_q, trial_d;
  logic [9:0] bit_q, bit_d;
  logic fin_q, fin_d;

  // one bit resolved per step, msb first
  always_comb begin
    trial_d = trial_q;
    bit_d = bit_q;
    fin_d = 1'b0;
    if (abort) begin
      bit_d = '0;
    end else if (start) begin
      bit_d = 10'h200;
      trial_d = 10'h200;
    end else if (step_en && bit_q != '0) begin
      if (cmp_above) begin
        trial_d = trial_q & ~bit_q;
      end
      bit_d = bit_q >> 1;
      trial_d = trial_d | (bit_q >> 1);
      fin_d = (bit_q == 10'h001);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trial_q <= '0;
      bit_q <= '0;
      fin_q <= 1'b0;
    end else begin
      trial_q <= trial_d;
      bit_q <= bit_d;
      fin_q <= fin_d;
    end
  end

  assign trial = trial_q;
  assign busy = bit_q != '0;
  assign finish = fin_q;
endmodule
`default_nettype wire

// ==== verilog/sacs_top.sv ====
// converter control block with its register slave
// What this block does
// - any control register write aborts, then restarts in software trigger mode unless channel is all ones
// - compare off: done flag sets at end of every conversion
// - compare on: done flag sets only when compare is true
// - done flag clears on control write or low result read
// - done flag set with interrupt enable high raises interrupt
// - single mode: one conversion per write or per hardware trigger
// - continuous mode: back-to-back conversions after write or hardware event
// - five-bit channel field, codes 0 to 27 pick inputs in order
// - all-ones channel turns converter off and isolates input
// - all-ones write stops continuous mode without extra conversion
// - single mode returns to low power after each conversion
// - linear successive-approximation search, ten bits
// - results right-justified in ten or eight bit format
// - multiplexer offers up to 28 channels
// - conversion clock chosen from four sources
// - compare less-than or greater-or-equal against programmable value
// - hardware trigger input can start conversions
// - trigger select picks software write or hardware trigger
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module sacs_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [3:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // axi4-lite read
  input wire logic [3:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // analog front end
  input wire logic hw_trigger_in,
  input wire logic alt_clk_tick,
  input wire logic local_clk_tick,
  input wire logic cmp_above,
  output logic [4:0] mux_channel,
  output logic mux_isolate,
  output logic sar_power_on,
  output logic sample_en,
  output logic [9:0] dac_code,
  // status
  output logic conv_active,
  output logic irq
);
  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  sacs_pkg::sacs_sc1_t sc1_q, sc1_d;
  sacs_pkg::sacs_cfg_t cfg_q, cfg_d;
  logic [9:0] cmpv_q, cmpv_d;
  logic [9:0] res_q, res_d;
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [3:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d;
  logic [3:0] ws_q, ws_d;
  logic bv_q, bv_d, rv_q, rv_d;
  logic [1:0] br_q, br_d, rr_q, rr_d;
  logic [31:0] rd_q, rd_d;
  sacs_pkg::sacs_state_t st_q, st_d;
  logic [3:0] settle_q, settle_d;
  logic half_q, half_d;
  logic trig_prev_q, trig_prev_d;
  logic sc1_wr, res_rd, conv_end, cmp_true, step_en, hw_edge, start, abort;
  logic [9:0] trial;
  logic busy, finish;

  function automatic logic is_off(input logic [4:0] ch);
    is_off = (ch == sacs_pkg::CH_OFF);
  endfunction

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  assign s_awready = !aw_hold_q && !bv_q;
  assign s_wready = !w_hold_q && !bv_q;
  assign s_arready = !rv_q;
  assign s_bvalid = bv_q;
  assign s_bresp = br_q;
  assign s_rvalid = rv_q;
  assign s_rresp = rr_q;
  assign s_rdata = rd_q;

  logic [3:0] wa;
  logic [31:0] wdat;
  logic [3:0] wstb;
  logic wr_go;
  always_comb begin
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    awa_d = awa_q;
    wd_d = wd_q;
    ws_d = ws_q;
    if (s_awvalid && s_awready) begin
      aw_hold_d = 1'b1;
      awa_d = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      w_hold_d = 1'b1;
      wd_d = s_wdata;
      ws_d = s_wstrb;
    end
    wr_go = aw_hold_d && w_hold_d && !bv_q;
    wa = awa_d;
    wdat = wd_d;
    wstb = ws_d;
    if (wr_go) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
    end
  end

  // write decode and register update
  always_comb begin
    sc1_wr = 1'b0;
    cfg_d = cfg_q;
    cmpv_d = cmpv_q;
    bv_d = bv_q && !s_bready;
    br_d = br_q;
    if (wr_go) begin
      bv_d = 1'b1;
      br_d = sacs_pkg::RESP_OK;
      if (wa == sacs_pkg::OFF_SC1) begin
        sc1_wr = wstb[0];
      end else if (wa == sacs_pkg::OFF_SC2) begin
        if (wstb[0]) begin
          cfg_d = {wdat[sacs_pkg::SC2_TRG], wdat[sacs_pkg::SC2_CMPE],
                   wdat[sacs_pkg::SC2_GTE], wdat[sacs_pkg::SC2_M8],
                   wdat[sacs_pkg::SC2_CLK +: 2]};
        end
      end else if (wa == sacs_pkg::OFF_CMP) begin
        if (wstb[0]) cmpv_d[7:0] = wdat[7:0];
        if (wstb[1]) cmpv_d[9:8] = wdat[9:8];
      end else if (wa == sacs_pkg::OFF_RES) begin
        br_d = sacs_pkg::RESP_OK;
      end else begin
        br_d = sacs_pkg::RESP_DECERR;
      end
    end
  end

  // read path
  always_comb begin
    res_rd = 1'b0;
    rv_d = rv_q && !s_rready;
    rr_d = rr_q;
    rd_d = rd_q;
    if (s_arvalid && s_arready) begin
      rv_d = 1'b1;
      rr_d = sacs_pkg::RESP_OK;
      rd_d = '0;
      if (s_araddr == sacs_pkg::OFF_SC1) begin
        rd_d[7:0] = sc1_q;
      end else if (s_araddr == sacs_pkg::OFF_SC2) begin
        rd_d[sacs_pkg::SC2_ACT] = busy || st_q != sacs_pkg::ST_IDLE;
        rd_d[6:0] = {cfg_q.trig_hw, cfg_q.cmp_en, cfg_q.cmp_gte, cfg_q.mode8,
                     1'b0, cfg_q.clk_sel};
      end else if (s_araddr == sacs_pkg::OFF_RES) begin
        rd_d[9:0] = res_q;
        res_rd = 1'b1;
      end else if (s_araddr == sacs_pkg::OFF_CMP) begin
        rd_d[9:0] = cmpv_q;
      end else begin
        rr_d = sacs_pkg::RESP_DECERR;
      end
    end
  end

  // ---------------------------------------------------------------
  // conversion clock select
  // ---------------------------------------------------------------
  always_comb begin
    half_d = !half_q;
    case (cfg_q.clk_sel)
      sacs_pkg::CLK_BUS: step_en = 1'b1;
      sacs_pkg::CLK_HALF: step_en = half_q;
      sacs_pkg::CLK_LOCAL: step_en = local_clk_tick;
      default: step_en = alt_clk_tick;
    endcase
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  assign hw_edge = hw_trigger_in && !trig_prev_q;
  logic [9:0] res_fmt, cmp_ref;
  always_comb begin
    res_fmt = cfg_q.mode8 ? {2'b00, trial[9:2]} : trial;
    // eight-bit mode compares the low byte of the value only
    cmp_ref = cfg_q.mode8 ? {2'b00, cmpv_q[7:0]} : cmpv_q;
    cmp_true = cfg_q.cmp_gte ? (res_fmt >= cmp_ref) : (res_fmt < cmp_ref);
  end
  assign conv_end = finish && st_q == sacs_pkg::ST_BITS;

  always_comb begin
    st_d = st_q;
    settle_d = settle_q;
    trig_prev_d = hw_trigger_in;
    start = 1'b0;
    abort = sc1_wr;
    if (sc1_wr) begin
      st_d = sacs_pkg::ST_IDLE;
      if (!is_off(wdat[4:0]) && !cfg_q.trig_hw) begin
        st_d = sacs_pkg::ST_SAMPLE;
        settle_d = '0;
      end
    end else begin
      case (st_q)
        sacs_pkg::ST_IDLE: begin
          if (cfg_q.trig_hw && hw_edge && !is_off(sc1_q.ch)) begin
            st_d = sacs_pkg::ST_SAMPLE;
            settle_d = '0;
          end
        end
        sacs_pkg::ST_SAMPLE: begin
          if (step_en) begin
            settle_d = settle_q + 4'h1;
            if (settle_q == sacs_pkg::SETTLE_CYC) begin
              st_d = sacs_pkg::ST_BITS;
              start = 1'b1;
            end
          end
        end
        sacs_pkg::ST_BITS: begin
          if (finish) st_d = sacs_pkg::ST_DONE;
        end
        default: begin
          // continuous mode repeats with either trigger select; otherwise drop to low power
          if (sc1_q.cont && !cfg_q.trig_hw) begin
            st_d = sacs_pkg::ST_SAMPLE;
            settle_d = '0;
          end else if (sc1_q.cont && cfg_q.trig_hw) begin
            st_d = sacs_pkg::ST_SAMPLE;
            settle_d = '0;
          end else begin
            st_d = sacs_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // flag, result and control register
  always_comb begin
    sc1_d = sc1_q;
    res_d = res_q;
    if (sc1_wr) begin
      sc1_d.ien = wdat[sacs_pkg::SC1_IEN];
      sc1_d.cont = wdat[sacs_pkg::SC1_CONT];
      sc1_d.ch = wdat[4:0];
    end
    if (sc1_wr || res_rd) sc1_d.done = 1'b0;
    if (conv_end && (!cfg_q.cmp_en || cmp_true)) begin
      sc1_d.done = 1'b1;
      res_d = res_fmt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sc1_q <= sacs_pkg::SC1_RST;
      cfg_q <= '0;
      cmpv_q <= '0;
      res_q <= '0;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awa_q <= '0;
      wd_q <= '0;
      ws_q <= '0;
      bv_q <= 1'b0;
      rv_q <= 1'b0;
      br_q <= '0;
      rr_q <= '0;
      rd_q <= '0;
      st_q <= sacs_pkg::ST_IDLE;
      settle_q <= '0;
      half_q <= 1'b0;
      trig_prev_q <= 1'b0;
    end else begin
      sc1_q <= sc1_d;
      cfg_q <= cfg_d;
      cmpv_q <= cmpv_d;
      res_q <= res_d;
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      bv_q <= bv_d;
      rv_q <= rv_d;
      br_q <= br_d;
      rr_q <= rr_d;
      rd_q <= rd_d;
      st_q <= st_d;
      settle_q <= settle_d;
      half_q <= half_d;
      trig_prev_q <= trig_prev_d;
    end
  end

  sacs_sar_core u_core (
    .aclk(aclk),
    .aresetn(aresetn),
    .step_en(step_en),
    .start(start),
    .abort(abort),
    .cmp_above(cmp_above),
    .trial(trial),
    .busy(busy),
    .finish(finish)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign mux_channel = sc1_q.ch;
  assign mux_isolate = is_off(sc1_q.ch);
  assign sar_power_on = st_q != sacs_pkg::ST_IDLE;
  assign sample_en = st_q == sacs_pkg::ST_SAMPLE;
  assign dac_code = trial;
  assign conv_active = sar_power_on;
  assign irq = sc1_q.done && sc1_q.ien;

  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    irq && !sc1_wr && !res_rd |=> irq) else $error("irq dropped while flag held");
  a_irq_on_done: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_end && !cfg_q.cmp_en && sc1_q.ien && !sc1_wr |=> irq)
    else $error("irq not raised on done");
  a_off_no_conv: assert property (@(posedge aclk) disable iff (!aresetn)
    mux_isolate |-> !sample_en) else $error("conversion while off");
  a_write_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    sc1_wr && !conv_end |=> !sc1_q.done) else $error("flag not cleared");
  a_done_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_end && !cfg_q.cmp_en |=> sc1_q.done) else $error("flag not set");
  a_cmp_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_end && cfg_q.cmp_en && !cmp_true && !sc1_q.done |=> !sc1_q.done)
    else $error("flag set on false compare");
  a_off_abort: assert property (@(posedge aclk) disable iff (!aresetn)
    sc1_wr && is_off(wdat[4:0]) |=> st_q == sacs_pkg::ST_IDLE)
    else $error("off write started conversion");
  a_sw_start: assert property (@(posedge aclk) disable iff (!aresetn)
    sc1_wr && !is_off(wdat[4:0]) && !cfg_q.trig_hw |=> sample_en)
    else $error("write did not start");
  a_single_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == sacs_pkg::ST_DONE && !sc1_q.cont && !sc1_wr |=> !sar_power_on)
    else $error("no low power after single");
endmodule
`default_nettype wire
